// ---- etfr_pkg.sv ----
// Package for the external temperature fault response block
// Summary of operation
// - Paged OT response byte 0x50, default 0xb8
// - Paged UT response byte 0x54, same layout
// - OT fault sets summary, OT bit, alert
// - UT fault sets summary, UT bit, alert
// - UT response latency may reach 90 ms
// - Response 00 keeps output running
// - Writing response 01 or 11 flags CML
// - Response 10 disables output, then retry policy
// - Any response sets status bit and alert
// - Latched bits clear only on listed events
// - Retry 000 never restarts until cleared/off
// - Retry 111 restarts forever at retry interval
// - Delay field bits 2:0 ignored
package etfr_pkg;
    // ------------------------------------------------------------
    // Command codes and layout
    // ------------------------------------------------------------
    localparam logic [7:0] ETFR_CMD_OT = 8'h50;
    localparam logic [7:0] ETFR_CMD_UT = 8'h54;
    localparam logic [7:0] ETFR_RESP_RST = 8'hb8;
    localparam int ETFR_RESP_HI = 7;
    localparam int ETFR_RESP_LO = 6;
    localparam int ETFR_RETRY_HI = 5;
    localparam int ETFR_RETRY_LO = 3;
    localparam logic [1:0] ETFR_RESP_CONT = 2'h0;
    localparam logic [1:0] ETFR_RESP_SHUT = 2'h2;
    localparam logic [2:0] ETFR_RETRY_NONE = 3'h0;
    localparam logic [2:0] ETFR_RETRY_FOREVER = 3'h7;
    // Temperature status bit positions
    localparam int ETFR_STAT_OT = 7;
    localparam int ETFR_STAT_UT = 4;
    localparam logic [7:0] ETFR_STAT_RST = 8'h00;
    // Timing
    localparam int ETFR_CLK_HZ = 10_000_000;
    localparam int ETFR_UT_LAT_MS = 90;
    localparam int ETFR_UT_LAT_CYC = ETFR_UT_LAT_MS * (ETFR_CLK_HZ / 1000);
    localparam int ETFR_RETRY_MS = 350;
    localparam int ETFR_RETRY_CYC = ETFR_RETRY_MS * (ETFR_CLK_HZ / 1000);

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic page;
        logic [7:0] code;
        logic [7:0] data;
    } etfr_cmd_type;

    typedef struct packed {
        logic clear_faults;
        logic restore_user;
        logic vendor_reset;
    } etfr_clr_type;
endpackage : etfr_pkg

// ---- etfr_chan.sv ----
// One output channel's fault response engine
`timescale 1ns/10ps
module etfr_chan #(
    parameter int RETRY_CYC = etfr_pkg::ETFR_RETRY_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Settings and events
    input wire logic [7:0] ot_resp_i,
    input wire logic [7:0] ut_resp_i,
    input wire logic ot_fault_i,
    input wire logic ut_fault_i,
    input wire logic run_i,
    input wire logic clear_i,
    // Results
    output logic ot_flag_o,
    output logic ut_flag_o,
    output logic out_en_o
);
    import etfr_pkg::*;

    typedef enum logic [1:0] {ETFR_OFF, ETFR_ON, ETFR_HELD, ETFR_WAIT} etfr_st_type;

    etfr_st_type st_q, st_d;
    logic ot_q, ot_d, ut_q, ut_d, run_q, run_d;
    logic [31:0] cnt_q, cnt_d;
    logic ot_shut, ut_shut, shut, forever_retry;

    // ------------------------------------------------------------
    // Response decode; delay field never looked at
    // ------------------------------------------------------------
    always_comb begin
        ot_shut = ot_fault_i && ot_resp_i[ETFR_RESP_HI:ETFR_RESP_LO] == ETFR_RESP_SHUT;
        ut_shut = ut_fault_i && ut_resp_i[ETFR_RESP_HI:ETFR_RESP_LO] == ETFR_RESP_SHUT;
        shut = ot_shut || ut_shut;
        // Every fault that is shutting down must ask for retry, else the no-retry one wins
        forever_retry = (!ot_shut
            || ot_resp_i[ETFR_RETRY_HI:ETFR_RETRY_LO] == ETFR_RETRY_FOREVER)
            && (!ut_shut
            || ut_resp_i[ETFR_RETRY_HI:ETFR_RETRY_LO] == ETFR_RETRY_FOREVER);
    end

    always_comb begin
        run_d = run_i;
        // Set beats clear so a fault in the clear cycle is kept
        ot_d = ot_fault_i || (ot_q && !clear_i);
        ut_d = ut_fault_i || (ut_q && !clear_i);
        st_d = st_q;
        cnt_d = cnt_q;
        if (!run_i) begin
            st_d = ETFR_OFF;
        end else begin
            unique case (st_q)
                ETFR_OFF: begin
                    if (!run_q) st_d = ETFR_ON;
                end
                ETFR_ON: begin
                    if (shut) begin
                        st_d = forever_retry ? ETFR_WAIT : ETFR_HELD;
                        cnt_d = 32'h0;
                    end
                end
                ETFR_HELD: begin
                    if (clear_i) st_d = ETFR_ON;
                end
                ETFR_WAIT: begin
                    if (shut && !forever_retry) begin
                        st_d = ETFR_HELD;
                    end else if (cnt_q >= 32'(RETRY_CYC - 1)) begin
                        st_d = ETFR_ON;
                    end else begin
                        cnt_d = cnt_q + 32'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            st_q <= ETFR_OFF;
            ot_q <= 1'b0;
            ut_q <= 1'b0;
            run_q <= 1'b0;
            cnt_q <= 32'h0;
        end else begin
            st_q <= st_d;
            ot_q <= ot_d;
            ut_q <= ut_d;
            run_q <= run_d;
            cnt_q <= cnt_d;
        end
    end

    assign ot_flag_o = ot_q;
    assign ut_flag_o = ut_q;
    assign out_en_o = (st_q == ETFR_ON) && !shut;
endmodule : etfr_chan

// ---- etfr_top.sv ----
// Top of the external temperature fault response block
`timescale 1ns/10ps
module etfr_top #(
    parameter int PAGES = 2,
    parameter int RETRY_CYC = etfr_pkg::ETFR_RETRY_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Command port
    input wire etfr_pkg::etfr_cmd_type cmd_i,
    input wire etfr_pkg::etfr_clr_type clr_i,
    output logic [7:0] rd_data_o,
    // Channel side
    input wire logic [PAGES-1:0] ot_fault_i,
    input wire logic [PAGES-1:0] ut_fault_i,
    input wire logic [PAGES-1:0] run_i,
    input wire logic [PAGES-1:0] alert_mask_i,
    output logic [PAGES-1:0] out_en_o,
    // Status
    output logic [PAGES-1:0] temp_summary_o,
    output logic [PAGES*8-1:0] temp_status_o,
    output logic cml_fault_o,
    output logic alert_n_o
);
    import etfr_pkg::*;

    logic [7:0] ot_q [PAGES];
    logic [7:0] ot_d [PAGES];
    logic [7:0] ut_q [PAGES];
    logic [7:0] ut_d [PAGES];
    logic [7:0] rd_q, rd_d;
    logic cml_q, cml_d;
    logic [PAGES-1:0] ot_flag, ut_flag, clr_ch, run_q;
    logic any_alert, bad;
    logic clear_all;

    // ------------------------------------------------------------
    // Paged response bytes and CML check
    // ------------------------------------------------------------
    always_comb begin
        clear_all = clr_i.clear_faults | clr_i.restore_user | clr_i.vendor_reset;
        bad = cmd_i.data[ETFR_RESP_HI:ETFR_RESP_LO] == 2'h1
            || cmd_i.data[ETFR_RESP_HI:ETFR_RESP_LO] == 2'h3;
        cml_d = cml_q && !clear_all;
        for (int p = 0; p < PAGES; p++) begin
            ot_d[p] = ot_q[p];
            ut_d[p] = ut_q[p];
            if (cmd_i.wr && int'(cmd_i.page) == p && !bad) begin
                if (cmd_i.code == ETFR_CMD_OT) ot_d[p] = cmd_i.data;
                if (cmd_i.code == ETFR_CMD_UT) ut_d[p] = cmd_i.data;
            end
        end
        if (cmd_i.wr && bad && (cmd_i.code == ETFR_CMD_OT || cmd_i.code == ETFR_CMD_UT)) begin
            cml_d = 1'b1;
        end
        rd_d = 8'h00;
        if (cmd_i.code == ETFR_CMD_OT) rd_d = ot_q[cmd_i.page];
        if (cmd_i.code == ETFR_CMD_UT) rd_d = ut_q[cmd_i.page];
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            for (int p = 0; p < PAGES; p++) begin
                ot_q[p] <= ETFR_RESP_RST;
                ut_q[p] <= ETFR_RESP_RST;
            end
            rd_q <= 8'h00;
            cml_q <= 1'b0;
            run_q <= '0;
        end else begin
            ot_q <= ot_d;
            ut_q <= ut_d;
            rd_q <= rd_d;
            cml_q <= cml_d;
            run_q <= run_i;
        end
    end

    // ------------------------------------------------------------
    // Per channel engines
    // ------------------------------------------------------------
    // UT faults arrive from converter results, so up to 90 ms late
    for (genvar g = 0; g < PAGES; g++) begin : g_ch
        // Off then on cycle clears this page's bits
        assign clr_ch[g] = clear_all || (run_i[g] && !run_q[g]);
        etfr_chan #(.RETRY_CYC(RETRY_CYC)) u_ch (
            .ref_clk_i(ref_clk_i),
            .rstn_i(rstn_i),
            .ot_resp_i(ot_q[g]),
            .ut_resp_i(ut_q[g]),
            .ot_fault_i(ot_fault_i[g]),
            .ut_fault_i(ut_fault_i[g]),
            .run_i(run_i[g]),
            .clear_i(clr_ch[g]),
            .ot_flag_o(ot_flag[g]),
            .ut_flag_o(ut_flag[g]),
            .out_en_o(out_en_o[g])
        );
        assign temp_status_o[g*8 +: 8] = ETFR_STAT_RST
            | (8'(ot_flag[g]) << ETFR_STAT_OT)
            | (8'(ut_flag[g]) << ETFR_STAT_UT);
        assign temp_summary_o[g] = ot_flag[g] | ut_flag[g];
    end

    assign any_alert = |((ot_flag | ut_flag) & ~alert_mask_i) | cml_q;
    assign alert_n_o = !any_alert;
    assign cml_fault_o = cml_q;
    assign rd_data_o = rd_q;
endmodule : etfr_top

// ---- etfr_sensor.sv ----
// Far-side model: external temperature sensors seen through the converter
`timescale 1ns/10ps
module etfr_sensor #(
    parameter int LAT = 4
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Trip requests from the bench
    input wire logic [1:0] ot_trip_i,
    input wire logic [1:0] ut_trip_i,
    // Fault levels towards the block
    output logic [1:0] ot_fault_o,
    output logic [1:0] ut_fault_o
);
    logic [1:0] dl [LAT];
    assign ot_fault_o = ot_trip_i;
    // Under-temperature is only seen after conversion, so it lags
    assign ut_fault_o = dl[LAT-1];
    always @(posedge ref_clk_i) begin
        dl[0] <= rstn_i ? ut_trip_i : 2'h0;
        for (int i = 1; i < LAT; i++) dl[i] <= rstn_i ? dl[i-1] : 2'h0;
    end
endmodule : etfr_sensor

// ---- etfr_checker.sv ----
// Port checker for the temperature fault response top
`timescale 1ns/10ps
module etfr_checker #(
    parameter int PAGES = 2
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire etfr_pkg::etfr_cmd_type cmd_i,
    input wire etfr_pkg::etfr_clr_type clr_i,
    input wire logic [7:0] rd_data_o,
    input wire logic [PAGES-1:0] ot_fault_i,
    input wire logic [PAGES-1:0] ut_fault_i,
    input wire logic [PAGES-1:0] run_i,
    input wire logic [PAGES-1:0] alert_mask_i,
    input wire logic [PAGES-1:0] temp_summary_o,
    input wire logic [PAGES*8-1:0] temp_status_o,
    input wire logic cml_fault_o,
    input wire logic alert_n_o
);
    import etfr_pkg::*;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    property p_ot; ot_fault_i[0] |=> temp_status_o[7] && temp_summary_o[0]; endproperty
    a_ot: assert property (p_ot) else $error("ot flag missing");
    property p_ut; ut_fault_i[1] |=> temp_status_o[12] && temp_summary_o[1]; endproperty
    a_ut: assert property (p_ut) else $error("ut flag missing");
    property p_al; (temp_summary_o & ~alert_mask_i) != '0 |-> !alert_n_o; endproperty
    a_al: assert property (p_al) else $error("alert missing");
    property p_qt; temp_summary_o == '0 && !cml_fault_o |-> alert_n_o; endproperty
    a_qt: assert property (p_qt) else $error("stray alert");
    property p_bad; cmd_i.wr && cmd_i.code == ETFR_CMD_OT && cmd_i.data[6] |=> cml_fault_o;
    endproperty
    a_bad: assert property (p_bad) else $error("bad write not flagged");
    property p_hd; temp_summary_o[0] && clr_i == '0 && !$rose(run_i[0]) |=> temp_summary_o[0];
    endproperty
    a_hd: assert property (p_hd) else $error("flag lost");
    property p_cm; cml_fault_o && clr_i == '0 |=> cml_fault_o; endproperty
    a_cm: assert property (p_cm) else $error("cml lost");
    property p_rd; cmd_i.code != ETFR_CMD_OT && cmd_i.code != ETFR_CMD_UT |=> rd_data_o == 8'h00;
    endproperty
    a_rd: assert property (p_rd) else $error("read of other code");
endmodule : etfr_checker
bind etfr_top etfr_checker #(.PAGES(PAGES)) chk (.ref_clk_i, .rstn_i, .cmd_i, .clr_i,
    .rd_data_o, .ot_fault_i, .ut_fault_i, .run_i, .alert_mask_i, .temp_summary_o,
    .temp_status_o, .cml_fault_o, .alert_n_o);

// ---- etfr_top_tb.sv ----
// Testbench for the temperature fault response top
`timescale 1ns/10ps
module etfr_top_tb;
    import etfr_pkg::*;
    localparam int RC = 20;
    localparam int LAT = 4;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    etfr_cmd_type cmd_i = '0;
    etfr_clr_type clr_i = '0;
    logic [1:0] ot_trip = 2'h0, ut_trip = 2'h0, run_i = 2'h0, mask_i = 2'h0;
    logic [1:0] ot_f, ut_f, en, summ;
    logic [15:0] stat;
    logic [7:0] rd;
    logic cml, al_n;
    int err_total = 0, check_count = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    etfr_top #(.PAGES(2), .RETRY_CYC(RC)) dut (.ref_clk_i, .rstn_i, .cmd_i, .clr_i,
        .rd_data_o(rd), .ot_fault_i(ot_f), .ut_fault_i(ut_f), .run_i, .alert_mask_i(mask_i),
        .out_en_o(en), .temp_summary_o(summ), .temp_status_o(stat), .cml_fault_o(cml),
        .alert_n_o(al_n));
    etfr_sensor #(.LAT(LAT)) far (.ref_clk_i, .rstn_i, .ot_trip_i(ot_trip),
        .ut_trip_i(ut_trip), .ot_fault_o(ot_f), .ut_fault_o(ut_f));
    task cyc(input int n); repeat (n) @(negedge ref_clk_i); endtask : cyc
    task chk(input string n, input logic [15:0] e, input logic [15:0] s);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task wr(input logic p, input logic [7:0] c, input logic [7:0] d);
        cmd_i = '{1'b1, p, c, d};
        cyc(1);
        cmd_i = '{1'b0, p, 8'h00, 8'h00};
        // Idle edge so a following call never drives the bus twice in one step
        cyc(1);
    endtask : wr
    task rdc(input logic p, input logic [7:0] c, input logic [7:0] e);
        cmd_i = '{1'b0, p, c, 8'h00};
        cyc(2);
        chk("rd_data", {8'h00, e}, {8'h00, rd});
    endtask : rdc
    task clr(input etfr_clr_type v); clr_i = v; cyc(1); clr_i = '0; endtask : clr
    task finish_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test
    // Watchdog: the whole sequence needs about 115 cycles
    initial begin
        cyc(3000);
        err_total++;
        $display("BAD watchdog exp %s got %s", "finish", "timeout");
        finish_test();
    end
    initial begin
        cyc(10);
        rstn_i = 1'b1;
        for (int i = 0; i < 4; i++) begin
            rdc(i[0], i[1] ? ETFR_CMD_UT : ETFR_CMD_OT, 8'hb8);
        end
        wr(1'b0, ETFR_CMD_OT, 8'h87);
        rdc(1'b1, ETFR_CMD_OT, 8'hb8);
        wr(1'b0, ETFR_CMD_OT, 8'h40);
        wr(1'b0, ETFR_CMD_UT, 8'hc0);
        rdc(1'b0, ETFR_CMD_OT, 8'h87);
        rdc(1'b0, ETFR_CMD_UT, 8'hb8);
        chk("cml", 16'h0001, {15'h0, cml});
        chk("alert_n", 16'h0000, {15'h0, al_n});
        clr('{1'b1, 1'b0, 1'b0});
        chk("cml", 16'h0000, {15'h0, cml});
        run_i = 2'h3;
        cyc(2);
        chk("out_en", 16'h0003, {14'h0, en});
        ot_trip = 2'h1;
        cyc(1);
        chk("status", 16'h0080, stat);
        chk("out_en", 16'h0002, {14'h0, en});
        chk("alert_n", 16'h0000, {15'h0, al_n});
        ot_trip = 2'h0;
        cyc(RC + 5);
        chk("out_en", 16'h0002, {14'h0, en});
        clr('{1'b0, 1'b1, 1'b0});
        cyc(2);
        chk("status", 16'h0000, stat);
        chk("out_en", 16'h0003, {14'h0, en});
        ut_trip = 2'h2;
        cyc(LAT + 1);
        chk("status", 16'h1000, stat);
        chk("out_en", 16'h0001, {14'h0, en});
        ut_trip = 2'h0;
        cyc(LAT + RC + 5);
        chk("out_en", 16'h0003, {14'h0, en});
        chk("status", 16'h1000, stat);
        clr('{1'b0, 1'b0, 1'b1});
        chk("status", 16'h0000, stat);
        wr(1'b0, ETFR_CMD_UT, 8'h00);
        ut_trip = 2'h1;
        cyc(LAT + 2);
        chk("out_en", 16'h0003, {14'h0, en});
        chk("status", 16'h0010, stat);
        mask_i = 2'h3;
        cyc(1);
        chk("alert_n", 16'h0001, {15'h0, al_n});
        ut_trip = 2'h0;
        cyc(LAT + 1);
        run_i = 2'h0;
        cyc(2);
        run_i = 2'h3;
        cyc(2);
        chk("status", 16'h0000, stat);
        finish_test();
    end
endmodule : etfr_top_tb
